// ===== design/fps_consts.vh
`ifndef FPS_CONSTS_VH
`define FPS_CONSTS_VH

`define FPS_KEY_CODE1 8'ha5
`define FPS_KEY_CODE2 8'hf1

`define FPS_KEY_LOCKED 2'h0
`define FPS_KEY_FIRST 2'h1
`define FPS_KEY_ARMED 2'h2
`define FPS_KEY_DISABLED 2'h3

`define FPS_WE_BIT 0
`define FPS_EE_BIT 1

`define FPS_PAGE_LSB 9
`define FPS_PAGE_MSB 12
`define FPS_FLASH_BYTES 8192
`define FPS_LOCK_ADDR 13'h1dff
`define FPS_LOCK_PAGE 4'he
`define FPS_RSVD_BASE 16'h1e00
`define FPS_RSVD_LAST 16'h1fff
`define FPS_ERASED 8'hff
`define FPS_PAGE_LAST_OFS 13'h01ff
`define FPS_ALL_LAST 13'h1fff

`define FPS_OP_RD 2'h0
`define FPS_OP_WR 2'h1
`define FPS_OP_ER 2'h2

`define FPS_CLK_KHZ 25000
`define FPS_ERASE_MS 10
`define FPS_WRITE_US 40
`define FPS_ERASE_CYC (`FPS_ERASE_MS * `FPS_CLK_KHZ)
`define FPS_WRITE_CYC ((`FPS_WRITE_US * `FPS_CLK_KHZ + 999) / 1000)

`endif

// ===== design/fps_flash_ctrl.v
// How it works
// - Key codes first then second must be written before any CPU write or erase.
// - No spacing between the two key writes matters, only order and value.
// - Wrong code or wrong order disables writes and erases until reset.
// - A write or erase attempted before the full key disables until reset.
// - Each completed CPU write or erase relocks the key; debug operations do not.
// - With write enable set, data-move writes go to flash, not data RAM.
// - Write enable stays set until software clears it.
// - Byte write stores old AND new; only erase returns bits to one.
// - Erase sets every byte of one 512-byte page to 0xff.
// - Erase and write enable plus key: redirected write erases its page.
// - Write enable only plus key: redirected write programs that one byte.
// - Operations are timed internally and stall the CPU until done.
// - Data-move reads always go to data RAM.
// - Last user byte is the lock byte; its complement counts pages locked.
// - Lock byte page is locked whenever any lock byte bit is zero.
// - Locked pages: debug refused, unlocked firmware error reset, locked allowed.
// - Lock byte reads follow the same split while any page is locked.
// - Firmware erasing lock page gets error reset; only device erase clears locks.
// - Changing a written lock byte is refused or error-resets.
// - Reserved top region access is refused or error-resets.
// - Debug refusals do nothing else; error resets raise the error flag.
// - A new lock byte takes effect only after the next reset.
`include "fps_consts.vh"

module fps_flash_ctrl #(
    parameter [23:0] ERASE_CYCLES = `FPS_ERASE_CYC,
    parameter [23:0] WRITE_CYCLES = `FPS_WRITE_CYC
) (
    input wire clk_sys_i,
    input wire reset_n_i,
    input wire por_n_i,
    input wire store_ctrl_wr_i,
    input wire [7:0] store_ctrl_wdata_i,
    input wire key_wr_i,
    input wire [7:0] key_wdata_i,
    input wire [15:0] cpu_pc_i,
    input wire ext_data_move_wr_i,
    input wire ext_data_move_rd_i,
    input wire [15:0] ext_data_move_addr_i,
    input wire [7:0] ext_data_move_wdata_i,
    input wire code_space_move_rd_i,
    input wire [15:0] code_space_move_addr_i,
    input wire dbg_rd_i,
    input wire dbg_wr_i,
    input wire dbg_erase_i,
    input wire dbg_dev_erase_i,
    input wire [15:0] dbg_addr_i,
    input wire [7:0] dbg_wdata_i,
    output reg store_write_enable_o,
    output reg store_erase_enable_o,
    output wire [1:0] key_state_o,
    output reg cpu_stall_o,
    output reg ext_ram_wr_o,
    output reg ext_ram_rd_o,
    output reg [15:0] ext_ram_addr_o,
    output reg [7:0] ext_ram_wdata_o,
    output reg [7:0] code_rdata_o,
    output reg code_rvalid_o,
    output reg [7:0] dbg_rdata_o,
    output reg dbg_done_o,
    output reg dbg_refused_o,
    output reg flash_error_reset_o,
    output reg flash_error_reset_flag_o,
    output reg [7:0] lock_setting_o
);

    reg [7:0] mem_q [0:`FPS_FLASH_BYTES-1];
    reg loaded_q;
    reg op_erase_q;
    reg op_dbg_q;
    reg [12:0] op_addr_q;
    reg [7:0] op_data_q;
    reg [23:0] timer_q;
    reg sweep_on_q;
    reg [12:0] sweep_q;
    reg [12:0] sweep_last_q;
    integer i;

    wire key_armed;
    wire op_done;
    wire cpu_flash_wr;
    wire dbg_req;
    wire pc_locked;
    wire [7:0] stored_lock;
    wire cpu_wr_bad;
    wire code_rd_bad;
    wire dbg_bad;
    wire [1:0] dbg_op;
    wire cpu_start;
    wire dbg_start;

    function page_locked;
        input [3:0] page;
        input [7:0] lock;
        reg [7:0] n;
        begin
            n = ~lock;
            page_locked = ({4'h0, page} < n) ||
                          (page == `FPS_LOCK_PAGE && n != 8'h00);
        end
    endfunction

    function prohibited;
        input [15:0] addr;
        input [1:0] op;
        input dbg;
        input pcl;
        input [7:0] lock;
        input [7:0] stored;
        reg rsvd;
        reg tgt;
        reg er_lockpg;
        reg lk_change;
        begin
            rsvd = (addr >= `FPS_RSVD_BASE);
            tgt = page_locked(addr[`FPS_PAGE_MSB:`FPS_PAGE_LSB], lock);
            er_lockpg = (op == `FPS_OP_ER) &&
                        (addr[`FPS_PAGE_MSB:`FPS_PAGE_LSB] == `FPS_LOCK_PAGE) &&
                        (!dbg || lock != `FPS_ERASED);
            lk_change = (op == `FPS_OP_WR) && (addr[12:0] == `FPS_LOCK_ADDR) &&
                        (stored != `FPS_ERASED);
            prohibited = rsvd || (tgt && (dbg || !pcl)) ||
                         er_lockpg || lk_change;
        end
    endfunction

    fps_key_seq u_key (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .key_wr_i(key_wr_i),
        .key_data_i(key_wdata_i),
        .attempt_i(cpu_flash_wr),
        .op_done_i(op_done && !op_dbg_q),
        .armed_o(key_armed),
        .state_o(key_state_o)
    );

    assign stored_lock = mem_q[`FPS_LOCK_ADDR];
    assign pc_locked = (cpu_pc_i < `FPS_RSVD_BASE) &&
                       page_locked(cpu_pc_i[`FPS_PAGE_MSB:`FPS_PAGE_LSB], lock_setting_o);
    assign op_done = cpu_stall_o && (timer_q == 24'h000000) && !sweep_on_q;

    // Debug requests win over a CPU write in the same cycle
    assign dbg_req = loaded_q && !cpu_stall_o &&
                     (dbg_rd_i || dbg_wr_i || dbg_erase_i || dbg_dev_erase_i);
    assign dbg_op = dbg_erase_i ? `FPS_OP_ER : (dbg_wr_i ? `FPS_OP_WR : `FPS_OP_RD);
    assign dbg_bad = prohibited(dbg_addr_i, dbg_op, 1'b1, 1'b0,
                                lock_setting_o, stored_lock);
    assign dbg_start = dbg_req && !dbg_dev_erase_i && !dbg_rd_i && !dbg_bad;

    assign cpu_flash_wr = ext_data_move_wr_i && store_write_enable_o &&
                          loaded_q && !cpu_stall_o && !dbg_req;
    assign cpu_wr_bad = prohibited(ext_data_move_addr_i,
                                   store_erase_enable_o ? `FPS_OP_ER : `FPS_OP_WR,
                                   1'b0, pc_locked, lock_setting_o, stored_lock);
    assign cpu_start = cpu_flash_wr && key_armed && !cpu_wr_bad;

    assign code_rd_bad = prohibited(code_space_move_addr_i, `FPS_OP_RD, 1'b0,
                                    pc_locked, lock_setting_o, stored_lock);

    // Lock setting sampled once after reset so writes apply only on the next one
    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            loaded_q <= 1'b0;
            lock_setting_o <= 8'h00;
        end else if (!loaded_q) begin
            loaded_q <= 1'b1;
            lock_setting_o <= stored_lock;
        end
    end

    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            store_write_enable_o <= 1'b0;
            store_erase_enable_o <= 1'b0;
        end else if (store_ctrl_wr_i) begin
            // Only software writes change these bits
            store_write_enable_o <= store_ctrl_wdata_i[`FPS_WE_BIT];
            store_erase_enable_o <= store_ctrl_wdata_i[`FPS_EE_BIT];
        end
    end

    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ext_ram_wr_o <= 1'b0;
            ext_ram_rd_o <= 1'b0;
            ext_ram_addr_o <= 16'h0000;
            ext_ram_wdata_o <= 8'h00;
        end else begin
            ext_ram_wr_o <= ext_data_move_wr_i && !store_write_enable_o;
            ext_ram_rd_o <= ext_data_move_rd_i;
            if (ext_data_move_wr_i || ext_data_move_rd_i) begin
                ext_ram_addr_o <= ext_data_move_addr_i;
                ext_ram_wdata_o <= ext_data_move_wdata_i;
            end
        end
    end

    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cpu_stall_o <= 1'b0;
            op_erase_q <= 1'b0;
            op_dbg_q <= 1'b0;
            op_addr_q <= 13'h0000;
            op_data_q <= 8'h00;
            timer_q <= 24'h000000;
            sweep_on_q <= 1'b0;
            sweep_q <= 13'h0000;
            sweep_last_q <= 13'h0000;
        end else if (cpu_stall_o) begin
            if (timer_q != 24'h000000) begin
                timer_q <= timer_q - 24'h000001;
            end
            if (sweep_on_q) begin
                if (sweep_q == sweep_last_q) begin
                    sweep_on_q <= 1'b0;
                end else begin
                    sweep_q <= sweep_q + 13'h0001;
                end
            end
            if (op_done) begin
                cpu_stall_o <= 1'b0;
            end
        end else if (cpu_start || dbg_start || (dbg_req && dbg_dev_erase_i)) begin
            cpu_stall_o <= 1'b1;
            op_dbg_q <= !cpu_start;
            if (cpu_start) begin
                op_erase_q <= store_erase_enable_o;
                op_addr_q <= ext_data_move_addr_i[12:0];
                op_data_q <= ext_data_move_wdata_i;
            end else begin
                op_erase_q <= dbg_erase_i || dbg_dev_erase_i;
                op_addr_q <= dbg_addr_i[12:0];
                op_data_q <= dbg_wdata_i;
            end
            if (dbg_req && dbg_dev_erase_i) begin
                // Device erase wipes every page, the lock byte included
                timer_q <= ERASE_CYCLES - 24'h000001;
                sweep_on_q <= 1'b1;
                sweep_q <= 13'h0000;
                sweep_last_q <= `FPS_ALL_LAST;
            end else if (cpu_start ? store_erase_enable_o : dbg_erase_i) begin
                // Erase data value is dropped, whole page swept
                timer_q <= ERASE_CYCLES - 24'h000001;
                sweep_on_q <= 1'b1;
                sweep_q <= {(cpu_start ? ext_data_move_addr_i[12:9] : dbg_addr_i[12:9]),
                            9'h000};
                sweep_last_q <= {(cpu_start ? ext_data_move_addr_i[12:9] : dbg_addr_i[12:9]),
                                 9'h000} | `FPS_PAGE_LAST_OFS;
            end else begin
                timer_q <= WRITE_CYCLES - 24'h000001;
            end
        end
    end

    // Flash array keeps its contents across system reset
    always @(posedge clk_sys_i or negedge por_n_i) begin
        if (!por_n_i) begin
            for (i = 0; i < `FPS_FLASH_BYTES; i = i + 1) begin
                mem_q[i] <= `FPS_ERASED;
            end
        end else if (sweep_on_q) begin
            mem_q[sweep_q] <= `FPS_ERASED;
        end else if (op_done && !op_erase_q) begin
            mem_q[op_addr_q] <= mem_q[op_addr_q] & op_data_q;
        end
    end

    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            code_rdata_o <= 8'h00;
            code_rvalid_o <= 1'b0;
            dbg_rdata_o <= 8'h00;
            dbg_done_o <= 1'b0;
            dbg_refused_o <= 1'b0;
        end else begin
            code_rvalid_o <= 1'b0;
            dbg_done_o <= 1'b0;
            dbg_refused_o <= 1'b0;
            if (code_space_move_rd_i && loaded_q && !cpu_stall_o && !code_rd_bad) begin
                code_rdata_o <= mem_q[code_space_move_addr_i[12:0]];
                code_rvalid_o <= 1'b1;
            end
            if (dbg_req && !dbg_dev_erase_i && dbg_bad) begin
                dbg_refused_o <= 1'b1;
            end else if (dbg_req && dbg_rd_i) begin
                dbg_rdata_o <= mem_q[dbg_addr_i[12:0]];
                dbg_done_o <= 1'b1;
            end
            if (op_done && op_dbg_q) begin
                dbg_done_o <= 1'b1;
            end
        end
    end

    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            flash_error_reset_o <= 1'b0;
        end else begin
            flash_error_reset_o <= (cpu_flash_wr && key_armed && cpu_wr_bad) ||
                                   (code_space_move_rd_i && loaded_q && !cpu_stall_o &&
                                    code_rd_bad);
        end
    end

    // Flag survives the system reset it causes
    always @(posedge clk_sys_i or negedge por_n_i) begin
        if (!por_n_i) begin
            flash_error_reset_flag_o <= 1'b0;
        end else if (flash_error_reset_o) begin
            flash_error_reset_flag_o <= 1'b1;
        end
    end

endmodule

// ===== design/fps_key_seq.v
`include "fps_consts.vh"

module fps_key_seq (
    input wire clk_sys_i,
    input wire reset_n_i,
    input wire key_wr_i,
    input wire [7:0] key_data_i,
    input wire attempt_i,
    input wire op_done_i,
    output wire armed_o,
    output wire [1:0] state_o
);

    reg [1:0] state_q;
    reg [1:0] state_d;

    assign armed_o = (state_q == `FPS_KEY_ARMED);
    assign state_o = state_q;

    always @* begin
        state_d = state_q;
        case (state_q)
            `FPS_KEY_LOCKED: begin
                if (key_wr_i) begin
                    state_d = (key_data_i == `FPS_KEY_CODE1) ? `FPS_KEY_FIRST
                                                             : `FPS_KEY_DISABLED;
                end else if (attempt_i) begin
                    state_d = `FPS_KEY_DISABLED;
                end
            end
            `FPS_KEY_FIRST: begin
                if (key_wr_i) begin
                    state_d = (key_data_i == `FPS_KEY_CODE2) ? `FPS_KEY_ARMED
                                                             : `FPS_KEY_DISABLED;
                end else if (attempt_i) begin
                    state_d = `FPS_KEY_DISABLED;
                end
            end
            `FPS_KEY_ARMED: begin
                if (key_wr_i) begin
                    state_d = `FPS_KEY_DISABLED;
                end else if (op_done_i) begin
                    state_d = `FPS_KEY_LOCKED;
                end
            end
            `FPS_KEY_DISABLED: begin
                state_d = `FPS_KEY_DISABLED;
            end
            default: begin
                state_d = `FPS_KEY_DISABLED;
            end
        endcase
    end

    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= `FPS_KEY_LOCKED;
        end else begin
            state_q <= state_d;
        end
    end

endmodule

// ===== testbench/fps_cpu_model.sv
module fps_cpu_model (
    input wire logic clk_sys_i,
    input wire logic cpu_stall_o,
    output logic store_ctrl_wr_i,
    output logic key_wr_i,
    output logic ext_data_move_wr_i,
    output logic ext_data_move_rd_i,
    output logic code_space_move_rd_i,
    output logic dbg_rd_i,
    output logic dbg_wr_i,
    output logic dbg_erase_i,
    output logic dbg_dev_erase_i,
    output logic [7:0] store_ctrl_wdata_i,
    output logic [7:0] key_wdata_i,
    output logic [7:0] ext_data_move_wdata_i,
    output logic [7:0] dbg_wdata_i,
    output logic [15:0] cpu_pc_i,
    output logic [15:0] ext_data_move_addr_i,
    output logic [15:0] code_space_move_addr_i,
    output logic [15:0] dbg_addr_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic hung = 1'b0;
    logic [8:0] strobe = 9'h000;
    logic [15:0] addr = 16'h0;
    logic [7:0] data = 8'h0;
    assign {dbg_dev_erase_i, dbg_erase_i, dbg_wr_i, dbg_rd_i, code_space_move_rd_i,
        ext_data_move_rd_i, ext_data_move_wr_i, key_wr_i, store_ctrl_wr_i} = strobe;
    assign ext_data_move_addr_i = addr;
    assign code_space_move_addr_i = addr;
    assign dbg_addr_i = addr;
    assign {store_ctrl_wdata_i, key_wdata_i, ext_data_move_wdata_i, dbg_wdata_i} = {4{data}};
    initial cpu_pc_i = 16'h0;
    task automatic req(input int k, input logic [15:0] a, input logic [7:0] d);
        int n;
        @(negedge clk_sys_i);
        if (k == 9) begin
            cpu_pc_i = a;
        end else begin
            addr = a;
            data = d;
            strobe = 9'h001 << k;
            @(negedge clk_sys_i);
            strobe = 9'h000;
            // Released lines must not keep the old value
            addr = ~a;
            data = ~d;
        end
        n = 0;
        while (cpu_stall_o === 1'b1 && n < 20000) begin
            @(negedge clk_sys_i);
            n++;
        end
        if (n == 20000) hung = 1'b1;
    endtask
endmodule

// ===== testbench/fps_flash_monitor.sv
module fps_flash_monitor #(
    parameter [23:0] WRITE_CYCLES = 24'h000005
) (
    input wire clk_sys_i,
    input wire reset_n_i,
    input wire store_ctrl_wr_i,
    input wire key_wr_i,
    input wire [7:0] key_wdata_i,
    input wire ext_data_move_wr_i,
    input wire ext_data_move_rd_i,
    input wire [15:0] ext_data_move_addr_i,
    input wire dbg_rd_i,
    input wire dbg_wr_i,
    input wire dbg_erase_i,
    input wire dbg_dev_erase_i,
    input wire [15:0] dbg_addr_i,
    input wire store_write_enable_o,
    input wire store_erase_enable_o,
    input wire [1:0] key_state_o,
    input wire cpu_stall_o,
    input wire ext_ram_wr_o,
    input wire ext_ram_rd_o,
    input wire [15:0] ext_ram_addr_o,
    input wire dbg_done_o,
    input wire dbg_refused_o,
    input wire flash_error_reset_o,
    input wire flash_error_reset_flag_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (!reset_n_i);
    // Debug wins over a CPU write in the same cycle
    wire dbg_any = dbg_rd_i | dbg_wr_i | dbg_erase_i | dbg_dev_erase_i;
    wire take_c = ext_data_move_wr_i & store_write_enable_o & !cpu_stall_o & !dbg_any;
    wire key_take = key_wr_i & !cpu_stall_o & (key_state_o == 2'h0);
    logic [23:0] cnt_q;
    logic wr_op_q;
    // Debug operations leave the key alone, so relock is checked for CPU ops only
    logic cpu_op_q;
    sequence armed_take;
        take_c && key_state_o == 2'h2 && $past(reset_n_i);
    endsequence
    sequence bare_take;
        take_c && key_state_o != 2'h2 && $past(reset_n_i);
    endsequence
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_q <= 24'h000000;
            wr_op_q <= 1'b0;
            cpu_op_q <= 1'b0;
        end else begin
            cpu_op_q <= (take_c && key_state_o == 2'h2) || (cpu_op_q && cpu_stall_o);
            cnt_q <= cpu_stall_o ? cnt_q + 24'h000001 : 24'h000000;
            wr_op_q <= (take_c && key_state_o == 2'h2 && !store_erase_enable_o)
                || (wr_op_q && cpu_stall_o);
        end
    end
    stall_start_a: assert property (armed_take |=> cpu_stall_o || flash_error_reset_o)
        else $error("armed write did not start");
    write_time_a: assert property ($fell(cpu_stall_o) && wr_op_q |-> cnt_q == WRITE_CYCLES)
        else $error("byte write stall length wrong");
    unarmed_block_a: assert property (bare_take |=> key_state_o == 2'h3 && !cpu_stall_o)
        else $error("unarmed write not blocked");
    key_sticky_a: assert property (key_state_o == 2'h3 |=> key_state_o == 2'h3)
        else $error("disabled key left its state");
    key_first_a: assert property (key_take && key_wdata_i == 8'ha5 && $past(reset_n_i)
        |=> key_state_o == 2'h1) else $error("first code not seen");
    key_wrong_a: assert property (key_take && key_wdata_i != 8'ha5 && $past(reset_n_i)
        |=> key_state_o == 2'h3) else $error("wrong code not disabling");
    key_relock_a: assert property ($fell(cpu_stall_o) && cpu_op_q |-> key_state_o == 2'h0)
        else $error("key not relocked");
    we_hold_a: assert property (store_write_enable_o && !store_ctrl_wr_i |=> store_write_enable_o)
        else $error("write enable dropped");
    ram_read_a: assert property (ext_data_move_rd_i |=> ext_ram_rd_o
        && ext_ram_addr_o == $past(ext_data_move_addr_i)) else $error("data read not to RAM");
    ram_write_block_a: assert property (ext_data_move_wr_i && store_write_enable_o
        |=> !ext_ram_wr_o) else $error("flash write reached RAM");
    dbg_reserved_a: assert property (dbg_rd_i && !cpu_stall_o && dbg_addr_i >= 16'h1e00
        && $past(reset_n_i) |=> dbg_refused_o && !dbg_done_o && !flash_error_reset_o)
        else $error("reserved debug read not refused");
    err_flag_a: assert property (flash_error_reset_o |=> flash_error_reset_flag_o)
        else $error("error flag not set");
endmodule

bind fps_flash_ctrl fps_flash_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) u_fps_flash_monitor (.*);

// ===== testbench/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CTL = 0, KEY = 1, XWR = 2, XRD = 3, CRD = 4, DRD = 5, DWR = 6, DER = 7;
    localparam int DEV = 8, PC = 9, KS = 0, CD = 1, DD = 2, DN = 3, DF = 4, ER = 5, FL = 6;
    localparam int LK = 7, RA = 8, RW = 9, WE = 10, NO = 11, EE = 12;
    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic por_n_i = 1'b0;
    logic store_ctrl_wr_i, key_wr_i, ext_data_move_wr_i, ext_data_move_rd_i, code_space_move_rd_i;
    logic dbg_rd_i, dbg_wr_i, dbg_erase_i, dbg_dev_erase_i;
    logic [7:0] store_ctrl_wdata_i, key_wdata_i, ext_data_move_wdata_i, dbg_wdata_i;
    logic [15:0] cpu_pc_i, ext_data_move_addr_i, code_space_move_addr_i, dbg_addr_i;
    logic store_write_enable_o, store_erase_enable_o, cpu_stall_o, ext_ram_wr_o, ext_ram_rd_o;
    logic code_rvalid_o, dbg_done_o, dbg_refused_o, flash_error_reset_o, flash_error_reset_flag_o;
    logic [1:0] key_state_o;
    logic [15:0] ext_ram_addr_o;
    logic [7:0] ext_ram_wdata_o, code_rdata_o, dbg_rdata_o, lock_setting_o;
    int failures = 0;
    int num_checks = 0;
    always #20 clk_sys_i = ~clk_sys_i;
    // Short counts keep the run brief; page sweep still sets erase length
    fps_flash_ctrl #(.ERASE_CYCLES(24'h000014), .WRITE_CYCLES(24'h000005)) u_fps_flash_ctrl (.*);
    fps_cpu_model u_fps_cpu_model (.*);
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    function automatic logic [15:0] obs(int s);
        case (s)
            KS: obs = 16'(key_state_o);
            CD: obs = code_rvalid_o ? 16'(code_rdata_o) : 16'hdead;
            DD: obs = dbg_done_o ? 16'(dbg_rdata_o) : 16'hdead;
            DN: obs = 16'(dbg_done_o);
            DF: obs = 16'(dbg_refused_o);
            ER: obs = 16'(flash_error_reset_o);
            FL: obs = 16'(flash_error_reset_flag_o);
            LK: obs = 16'(lock_setting_o);
            RA: obs = ext_ram_rd_o ? ext_ram_addr_o : 16'hdead;
            RW: obs = ext_ram_wr_o ? 16'(ext_ram_wdata_o) : 16'hdead;
            EE: obs = 16'(store_erase_enable_o);
            default: obs = 16'(store_write_enable_o);
        endcase
    endfunction
    task automatic t(int k, logic [15:0] a, logic [7:0] d, int s, logic [15:0] e);
        if (k >= 0) u_fps_cpu_model.req(k, a, d);
        if (u_fps_cpu_model.hung) begin
            failures++;
            $display("mismatch at %0t: request hung", $time);
            final_report();
        end
        if (s != NO) begin
            num_checks++;
            if (obs(s) !== e) begin
                failures++;
                $display("mismatch at %0t: view %0d got %h exp %h", $time, s, obs(s), e);
            end
        end
    endtask
    task automatic prog(logic [15:0] a, logic [7:0] d);
        t(KEY, 16'h0, 8'ha5, NO, 16'h0);
        t(KEY, 16'h0, 8'hf1, NO, 16'h0);
        t(XWR, a, d, NO, 16'h0);
    endtask
    task automatic rst(logic full);
        @(negedge clk_sys_i);
        reset_n_i = 1'b0;
        por_n_i = ~full;
        repeat (10) @(negedge clk_sys_i);
        reset_n_i = 1'b1;
        por_n_i = 1'b1;
        repeat (2) @(negedge clk_sys_i);
    endtask
    initial begin
        repeat (100000) @(posedge clk_sys_i);
        failures++;
        $display("mismatch at %0t: run too long", $time);
        final_report();
    end
    initial begin
        rst(1'b1);
        t(-1, 16'h0, 8'h0, LK, 16'h00ff);
        t(CTL, 16'h0, 8'h01, WE, 16'h0001);
        t(KEY, 16'h0, 8'ha5, KS, 16'h0001);
        t(KEY, 16'h0, 8'hf1, KS, 16'h0002);
        t(XWR, 16'h0100, 8'h3c, KS, 16'h0000);
        t(CRD, 16'h0100, 8'h0, CD, 16'h003c);
        t(CRD, 16'h0101, 8'h0, CD, 16'h00ff);
        prog(16'h0100, 8'hf0);
        t(CRD, 16'h0100, 8'h0, CD, 16'h0030);
        t(XRD, 16'h0123, 8'h0, RA, 16'h0123);
        t(-1, 16'h0, 8'h0, WE, 16'h0001);
        t(CTL, 16'h0, 8'h03, EE, 16'h0001);
        prog(16'h0105, 8'h00);
        t(CRD, 16'h0100, 8'h0, CD, 16'h00ff);
        t(CRD, 16'h01ff, 8'h0, CD, 16'h00ff);
        t(CTL, 16'h0, 8'h00, NO, 16'h0);
        t(XWR, 16'h0042, 8'h5a, RW, 16'h005a);
        $display("test program and erase done");
        rst(1'b0);
        t(KEY, 16'h0, 8'hf1, KS, 16'h0003);
        rst(1'b0);
        t(KEY, 16'h0, 8'ha5, NO, 16'h0);
        t(KEY, 16'h0, 8'h00, KS, 16'h0003);
        t(KEY, 16'h0, 8'hf1, KS, 16'h0003);
        rst(1'b0);
        t(CTL, 16'h0, 8'h01, NO, 16'h0);
        t(XWR, 16'h0200, 8'h00, KS, 16'h0003);
        prog(16'h0200, 8'h00);
        t(CRD, 16'h0200, 8'h0, CD, 16'h00ff);
        $display("test key refusals done");
        rst(1'b0);
        t(DRD, 16'h1e00, 8'h0, DF, 16'h0001);
        t(CRD, 16'h1fff, 8'h0, ER, 16'h0001);
        t(PC, 16'h0, 8'h0, FL, 16'h0001);
        rst(1'b0);
        t(CTL, 16'h0, 8'h01, NO, 16'h0);
        prog(16'h1dff, 8'hfd);
        t(-1, 16'h0, 8'h0, LK, 16'h00ff);
        rst(1'b0);
        t(-1, 16'h0, 8'h0, LK, 16'h00fd);
        t(DRD, 16'h0200, 8'h0, DF, 16'h0001);
        t(DRD, 16'h0400, 8'h0, DN, 16'h0001);
        t(DWR, 16'h0400, 8'h12, NO, 16'h0);
        t(DRD, 16'h0400, 8'h0, DD, 16'h0012);
        t(DER, 16'h0400, 8'h0, NO, 16'h0);
        t(DRD, 16'h0400, 8'h0, DD, 16'h00ff);
        t(DRD, 16'h1dff, 8'h0, DF, 16'h0001);
        t(DRD, 16'h1c00, 8'h0, DF, 16'h0001);
        t(PC, 16'h0800, 8'h0, NO, 16'h0);
        t(CRD, 16'h0000, 8'h0, ER, 16'h0001);
        t(PC, 16'h0000, 8'h0, NO, 16'h0);
        t(CRD, 16'h1dff, 8'h0, CD, 16'h00fd);
        t(CTL, 16'h0, 8'h03, NO, 16'h0);
        prog(16'h1c00, 8'h00);
        t(-1, 16'h0, 8'h0, ER, 16'h0001);
        rst(1'b0);
        t(CTL, 16'h0, 8'h01, NO, 16'h0);
        prog(16'h1dff, 8'h00);
        t(-1, 16'h0, 8'h0, ER, 16'h0001);
        rst(1'b0);
        t(DWR, 16'h1dff, 8'h00, DF, 16'h0001);
        t(DEV, 16'h0, 8'h0, DN, 16'h0001);
        rst(1'b0);
        t(-1, 16'h0, 8'h0, LK, 16'h00ff);
        t(DRD, 16'h1dff, 8'h0, DD, 16'h00ff);
        $display("test security done");
        final_report();
    end
endmodule
